// file: dv/asci_host.sv
// host model: sends telegrams, takes reply characters
`timescale 1ns/1ns
`default_nettype none
module asci_host (
  input  wire logic       clk,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  output logic            tx_ready
);
  logic        slow = 1'b0;
  logic [79:0] rsp  = '0;
  int          n    = 0;
  initial rx_data = 8'h00;
  initial rx_valid = 1'b0;
  initial tx_ready = 1'b1;
  // a busy host stalls every other cycle
  always @(negedge clk) tx_ready <= slow ? ~tx_ready : 1'b1;
  always @(posedge clk) if (tx_valid && tx_ready) begin
    rsp <= {rsp[71:0], tx_data};
    n   <= n + 1;
  end
  task automatic clear;
    rsp = '0;
    n = 0;
  endtask : clear
  // id, command, optional five digits, cr
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clk);
      rx_data  <= s[i];
      rx_valid <= 1'b1;
    end
    @(negedge clk);
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data; // released line shows no stale char
  endtask : send
endmodule : asci_host
`default_nettype wire

// file: dv/asci_monitor.sv
// assertion checker on the ports of the ascii command interpreter
`timescale 1ns/1ns
`default_nettype none
module asci_monitor (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic        tx_driver_en,
  input wire logic [1:0]  duplex_select,
  input wire logic        rx_pins_analog,
  input wire logic        instantaneous_output,
  input wire logic        stddev_enable,
  input wire logic [16:0] analog_slope_cal,
  input wire logic [16:0] analog_offset_cal,
  input wire logic        nv_write,
  input wire logic [16:0] key_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_stall; tx_valid && !tx_ready; endsequence
  sequence s_held; tx_valid && $stable(tx_data); endsequence
  AST_TX_HOLD: assert property (s_stall |=> s_held)
    else $error("reply char changed while stalled");
  AST_DRV_FULL: assert property (duplex_select == 2'd2 |=> tx_driver_en)
    else $error("driver off in driven mode");
  AST_DRV_TX: assert property (tx_valid |-> tx_driver_en)
    else $error("reply with driver off");
  AST_STDDEV: assert property (instantaneous_output |=> !stddev_enable)
    else $error("deviation on with instantaneous output");
  AST_SLOPE: assert property (analog_slope_cal inside {[5900:61000]})
    else $error("slope out of range");
  AST_OFFSET: assert property (analog_offset_cal inside {[800:1200]})
    else $error("offset out of range");
  AST_NO_FULL: assert property (
    rx_pins_analog && duplex_select == 2'd0 |=> duplex_select != 2'd1)
    else $error("full duplex taken with analogue rx pins");
  AST_NV_PULSE: assert property (nv_write |=> !nv_write)
    else $error("store pulse too long");
  AST_KEY_RST: assert property ($fell(srst) |-> key_level == 17'd0)
    else $error("key open after reset");
endmodule : asci_monitor
bind asci_interp asci_monitor u_asci_monitor (.clk, .srst, .tx_data,
  .tx_valid, .tx_ready, .tx_driver_en, .duplex_select, .rx_pins_analog,
  .instantaneous_output, .stddev_enable, .analog_slope_cal,
  .analog_offset_cal, .nv_write, .key_level);
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench of the ascii command interpreter
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  bad_count++; $display("Error t=%0t got %0h exp %0h", $time, a, e); end end
module tb_top;
  logic        clk, srst, rx_valid, tx_ready, pins_an, inst_out, auto_out;
  logic        tx_valid, tx_drv, interp, stddev, hold, dreq, nvw;
  logic [7:0]  rx_data, tx_data;
  logic [19:0] baud;
  logic [1:0]  frame, duplex;
  logic [16:0] key, slope, offs, bz, cz;
  int          bad_count = 0, samples_checked = 0, nvp = 0, dap = 0;
  asci_interp #(.HOLD_CYC(100)) u_asci_interp (.clk, .srst, .rx_data,
    .rx_valid, .tx_ready, .autonomous_output(auto_out),
    .rx_pins_analog(pins_an), .instantaneous_output(inst_out), .tx_data,
    .tx_valid, .tx_driver_en(tx_drv), .baud_rate(baud), .baud_frame(frame),
    .key_level(key), .interpreter_select(interp), .stddev_enable(stddev),
    .telegram_hold(hold), .regional_data_request(dreq),
    .analog_slope_cal(slope), .analog_offset_cal(offs),
    .chan_b_zero_scale(bz), .chan_b_full_scale(), .chan_c_zero_scale(),
    .chan_c_full_scale(cz), .duplex_select(duplex), .nv_write(nvw));
  asci_host u_asci_host (.clk, .tx_data, .tx_valid, .rx_data, .rx_valid,
    .tx_ready);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (nvw === 1'b1) nvp++;
  always @(posedge clk) if (dreq === 1'b1) dap++;
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  task automatic rst;
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
  endtask : rst
  // waits out the reply so telegrams never overlap
  task automatic cmd(input string s);
    int k;
    k = 0;
    u_asci_host.clear();
    u_asci_host.send(s);
    repeat (6) @(negedge clk);
    while (tx_valid !== 1'b0) begin
      @(negedge clk);
      k++;
      if (k > 300) begin
        bad_count++;
        conclude();
      end
    end
  endtask : cmd
  task automatic t_reset;
    `CHK(key, 17'd0)
    `CHK(baud, 20'd9600)
    `CHK(duplex, 2'd2)
    `CHK(tx_drv, 1'b1)
    `CHK(stddev, 1'b0)
    `CHK(interp, 1'b0)
    `CHK(bz, 17'd30000)
    `CHK(hold, 1'b0)
    cmd("00DM00001\r");
    `CHK(duplex, 2'd2)
    cmd("01KY00001\r");
    `CHK(key, 17'd0)
    cmd("00KY00001\r");
    `CHK(key, 17'd1)
  endtask : t_reset
  task automatic t_baud;
    cmd("00BX00104\r");
    `CHK(baud, 20'd9600)
    cmd("00BX00103\r");
    `CHK(baud, 20'd921600)
    `CHK(nvp, 0)
    u_asci_host.slow = 1'b1;
    cmd("00BR\r");
    `CHK(u_asci_host.rsp, "00BR00103\r")
    `CHK(u_asci_host.n, 10)
    u_asci_host.slow = 1'b0;
    rst();
    `CHK(baud, 20'd9600)
    cmd("00KY00001\r");
    cmd("00BX00101\r");
    `CHK(baud, 20'd230400)
    cmd("00BX00102\r");
    `CHK(baud, 20'd460800)
    cmd("00BX00102\r");
    `CHK(nvp, 1)
    rst();
    `CHK(baud, 20'd460800)
    `CHK(frame, 2'd0)
    cmd("00BX\r");
    `CHK(u_asci_host.rsp, "00BX00102\r")
  endtask : t_baud
  task automatic t_params;
    cmd("00KY00001\r");
    cmd("00CA05899\r");
    `CHK(slope, 17'd60000)
    cmd("00CA61000\r");
    `CHK(slope, 17'd61000)
    cmd("00CB01201\r");
    `CHK(offs, 17'd1000)
    cmd("00CB00800\r");
    `CHK(offs, 17'd800)
    cmd("00BY30010\r");
    `CHK(bz, 17'd30010)
    cmd("00CZ39960\r");
    `CHK(cz, 17'd39960)
    cmd("00DE00001\r");
    `CHK(stddev, 1'b1)
    inst_out = 1'b1;
    @(negedge clk);
    `CHK(stddev, 1'b0)
    inst_out = 1'b0;
    cmd("00DV\r");
    `CHK(u_asci_host.rsp[79:48], "00DV")
    cmd("00DF00001\r");
    `CHK(slope, 17'd60000)
    `CHK(cz, 17'd30000)
    cmd("00KY00001\r");
    cmd("00DF00002\r");
    `CHK(nvp, 2)
  endtask : t_params
  task automatic t_duplex;
    auto_out = 1'b1;
    rst();
    cmd("00KY00001\r");
    pins_an = 1'b1;
    cmd("00DM00000\r");
    `CHK(duplex, 2'd0)
    `CHK(tx_drv, 1'b0)
    `CHK(hold, 1'b1)
    repeat (100) @(negedge clk);
    `CHK(hold, 1'b0)
    cmd("00DM00001\r");
    `CHK(duplex, 2'd0)
    pins_an = 1'b0;
    cmd("00DM00001\r");
    `CHK(duplex, 2'd1)
    cmd("00CI00001\r");
    `CHK(interp, 1'b1)
    cmd("00DA\r");
    `CHK(dap, 1)
    cmd("DA\r");
    `CHK(dap, 2)
  endtask : t_duplex
  initial begin
    srst = 1'b1;
    pins_an = 1'b0;
    inst_out = 1'b0;
    auto_out = 1'b0;
    rst();
    t_reset();
    t_baud();
    t_params();
    t_duplex();
    conclude();
  end
endmodule : tb_top
`default_nettype wire

// file: hdl/asci_baud_map.sv
// maps a baud code to the line rate in baud and its frame format
`timescale 1ns/1ns
`default_nettype none
module asci_baud_map (
  input  wire logic [16:0] code,
  output logic      [19:0] rate,
  output logic      [1:0]  frame
);
  logic [16:0] col;
  always_comb begin
    rate  = 20'd9600;
    frame = 2'd0;
    col   = 17'd0;
    if (code >= asci_pkg::EXT_BAUD_MIN) begin
      unique case (code[1:0])
        2'd1:    rate = 20'd230400;
        2'd2:    rate = 20'd460800;
        default: rate = 20'd921600;
      endcase
    end else if (code >= asci_pkg::STD_BAUD_MIN) begin
      col   = (code - asci_pkg::STD_BAUD_MIN) % 17'd8;
      frame = 2'(((code - asci_pkg::STD_BAUD_MIN) / 17'd8) % 17'd4);
      unique case (col[2:0])
        3'd0:    rate = 20'd1200;
        3'd1:    rate = 20'd2400;
        3'd2:    rate = 20'd4800;
        3'd3:    rate = 20'd9600;
        3'd4:    rate = 20'd19200;
        3'd5:    rate = 20'd38400;
        3'd6:    rate = 20'd57600;
        default: rate = 20'd115200;
      endcase
    end
  end
endmodule : asci_baud_map
`default_nettype wire

// file: hdl/asci_digits.sv
// converts a 17-bit value of at most 99999 into five ascii digits
`timescale 1ns/1ns
`default_nettype none
module asci_digits (
  input  wire logic [16:0] value,
  output logic      [39:0] ascii
);
  logic [16:0] rest;
  always_comb begin
    rest  = value;
    ascii = '0;
    for (int i = 0; i < 5; i++) begin
      ascii[8*i +: 8] = asci_pkg::CH_ZERO + 8'(rest % 17'd10);
      rest = rest / 17'd10;
    end
  end
endmodule : asci_digits
`default_nettype wire

// file: hdl/asci_interp.sv
// telegram parser, parameter store and reply sender of the interpreter
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - change telegram: id, command, five digits, cr
// - query telegram: id, command, cr; reply
// - instrument id resets to 00
// - changes refused without open access key
// - first extended baud: switch now, volatile
// - identical repeat at new rate stores permanently
// - restart without confirm uses stored rate
// - extended baud accepts 101 to 103
// - 101..103 map to 230400..921600, 8n1
// - baud queries return last programmed setting
// - scaling holds 30000 plus ten times value
// - slope 60000 is unity, range 5900..61000
// - offset 1000 is zero, range 800..1200
// - interpreter select 0 standard, 1 regional
// - regional data request with or without address
// - stddev enable, default off, not instantaneous
// - defaults 1 working only, 2 also stored
// - duplex 0 half, 1 full gated, 2 driven
// - half duplex autonomous output held one minute
// - no half to full with rx pins analogue
// - version query only, returns version number, no date
module asci_interp #(
  parameter longint unsigned HOLD_CYC = 64'(asci_pkg::HOLD_S) *
                                        64'(asci_pkg::ONE_SECOND_CYC),
  parameter logic [16:0] VERSION_VAL = 17'd312,
  parameter logic [16:0] FW_DATE_VAL = 17'd10101,
  parameter logic [16:0] SLOPE_DEF   = asci_pkg::SLOPE_RST,
  parameter logic [16:0] OFFSET_DEF  = asci_pkg::OFFSET_RST
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        tx_ready,
  input  wire logic        autonomous_output,
  input  wire logic        rx_pins_analog,
  input  wire logic        instantaneous_output,
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  output logic             tx_driver_en,
  output logic      [19:0] baud_rate,
  output logic      [1:0]  baud_frame,
  output logic      [16:0] key_level,
  output logic             interpreter_select,
  output logic             stddev_enable,
  output logic             telegram_hold,
  output logic             regional_data_request,
  output logic      [16:0] analog_slope_cal,
  output logic      [16:0] analog_offset_cal,
  output logic      [16:0] chan_b_zero_scale,
  output logic      [16:0] chan_b_full_scale,
  output logic      [16:0] chan_c_zero_scale,
  output logic      [16:0] chan_c_full_scale,
  output logic      [1:0]  duplex_select,
  output logic             nv_write
);
  asci_pkg::asci_rx_t rx_q;
  asci_pkg::asci_tx_t tx_q;
  logic [15:0] id_q, cmd_q, inst_id_q;
  logic [2:0]  cnt_q;
  logic [16:0] par_q, key_q, baud_q, pend_q;
  logic        pend_vld_q;
  logic [16:0] slope_q, offset_q, by_q, bz_q, cy_q, cz_q;
  logic [1:0]  duplex_q;
  logic        interp_q, stddev_q;
  logic        exec_q, query_q, req_q, nvw_q, hold_q, drv_q;
  logic        sd_out_q, hold_out_q;
  // a minute of cycles overflows 32 bits
  logic [33:0] hold_cnt_q;
  logic [16:0] reply_val;
  logic [39:0] reply_dig;
  logic [79:0] reply_q;
  // powered-up image of the memory; a memory write changes it, and so does a standard baud change without nv_write
  logic [15:0] nv_id_q     = asci_pkg::ID_RESET;
  logic [16:0] nv_baud_q   = asci_pkg::STD_BAUD_RST;
  logic [16:0] nv_slope_q  = SLOPE_DEF;
  logic [16:0] nv_offset_q = OFFSET_DEF;
  logic [16:0] nv_by_q     = asci_pkg::SCALE_RST;
  logic [16:0] nv_bz_q     = asci_pkg::SCALE_RST;
  logic [16:0] nv_cy_q     = asci_pkg::SCALE_RST;
  logic [16:0] nv_cz_q     = asci_pkg::SCALE_RST;
  logic [1:0]  nv_duplex_q = 2'(asci_pkg::DUPLEX_RST);
  logic        nv_interp_q = 1'b0;
  logic        nv_stddev_q = 1'b0;
  logic [3:0]  tx_cnt_q;
  logic [7:0]  tx_data_q;
  logic        tx_valid_q;
  logic [19:0] rate_w, rate_q;
  logic [1:0]  frame_w, frame_q;
  logic        is_digit, writable, in_range, id_match;

  assign is_digit = rx_data >= asci_pkg::CH_ZERO && rx_data <= 8'h39;
  assign id_match = id_q == inst_id_q;

  // receive: id, command, up to five digits, then cr
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_q  <= asci_pkg::ASCI_RX_ID;
      cnt_q <= 3'd0;
      id_q  <= 16'h0000;
      cmd_q <= 16'h0000;
      par_q <= 17'd0;
      exec_q  <= 1'b0;
      query_q <= 1'b0;
    end else begin
      exec_q  <= 1'b0;
      query_q <= 1'b0;
      if (rx_valid) begin
        unique case (rx_q)
          asci_pkg::ASCI_RX_ID: begin
            if (rx_data == asci_pkg::CH_CR) begin
              cnt_q <= 3'd0;
            end else begin
              id_q  <= {id_q[7:0], rx_data};
              cnt_q <= cnt_q + 3'd1;
              if (cnt_q == 3'd1) begin
                rx_q  <= asci_pkg::ASCI_RX_CMD;
                cnt_q <= 3'd0;
              end
            end
          end
          asci_pkg::ASCI_RX_CMD: begin
            cmd_q <= {cmd_q[7:0], rx_data};
            cnt_q <= cnt_q + 3'd1;
            if (rx_data == asci_pkg::CH_CR) begin
              // regional data request may come without address
              if (interp_q && cnt_q == 3'd0) begin
                cmd_q   <= id_q;
                query_q <= 1'b1;
              end
              rx_q  <= asci_pkg::ASCI_RX_ID;
              cnt_q <= 3'd0;
            end else if (cnt_q == 3'd1) begin
              rx_q  <= asci_pkg::ASCI_RX_PARAM;
              cnt_q <= 3'd0;
              par_q <= 17'd0;
            end
          end
          asci_pkg::ASCI_RX_PARAM: begin
            if (rx_data == asci_pkg::CH_CR) begin
              // no digits is a query, five digits a change
              query_q <= cnt_q == 3'd0;
              exec_q  <= cnt_q == 3'(asci_pkg::PARAM_DIGITS);
              rx_q    <= asci_pkg::ASCI_RX_ID;
              cnt_q   <= 3'd0;
            end else if (is_digit && cnt_q < 3'(asci_pkg::PARAM_DIGITS)) begin
              par_q <= 17'(par_q * 17'd10 + 17'(rx_data - asci_pkg::CH_ZERO));
              cnt_q <= cnt_q + 3'd1;
            end else begin
              rx_q <= asci_pkg::ASCI_RX_SKIP;
            end
          end
          default: begin
            if (rx_data == asci_pkg::CH_CR) begin
              rx_q  <= asci_pkg::ASCI_RX_ID;
              cnt_q <= 3'd0;
            end
          end
        endcase
      end
    end
  end

  // key gate and range check for the addressed command
  always_comb begin
    writable = key_q >= asci_pkg::KEY_USER;
    in_range = 1'b0;
    unique case (cmd_q)
      asci_pkg::CMD_KEY:      begin
        in_range = 1'b1;
        writable = 1'b1;
      end
      asci_pkg::CMD_ID:       in_range = par_q <= asci_pkg::ID_MAX;
      asci_pkg::CMD_STD_BAUD: in_range = par_q >= asci_pkg::STD_BAUD_MIN &&
                                         par_q <= asci_pkg::STD_BAUD_MAX;
      asci_pkg::CMD_EXT_BAUD: in_range = par_q >= asci_pkg::EXT_BAUD_MIN &&
                                         par_q <= asci_pkg::EXT_BAUD_MAX;
      asci_pkg::CMD_SLOPE:    in_range = par_q >= asci_pkg::SLOPE_MIN &&
                                         par_q <= asci_pkg::SLOPE_MAX;
      asci_pkg::CMD_OFFSET:   in_range = par_q >= asci_pkg::OFFSET_MIN &&
                                         par_q <= asci_pkg::OFFSET_MAX;
      asci_pkg::CMD_B_ZERO, asci_pkg::CMD_B_FULL,
      asci_pkg::CMD_C_ZERO, asci_pkg::CMD_C_FULL:
                              in_range = 1'b1;
      asci_pkg::CMD_INTERP, asci_pkg::CMD_STDDEV:
                              in_range = par_q <= 17'd1;
      asci_pkg::CMD_DEFAULTS: in_range = par_q <= asci_pkg::DEF_ALL;
      asci_pkg::CMD_DUPLEX:   in_range = par_q <= asci_pkg::DUPLEX_RST &&
                                 !(duplex_q == 2'(asci_pkg::DUPLEX_HALF) &&
                                   par_q != asci_pkg::DUPLEX_HALF &&
                                   rx_pins_analog);
      default:                in_range = 1'b0; // version is query only
    endcase
  end

  // parameter store; nv copies stand for the non-volatile memory
  always_ff @(posedge clk) begin
    if (srst) begin
      // restart loads the stored values
      inst_id_q <= nv_id_q;
      baud_q    <= nv_baud_q;
      key_q     <= 17'd0;
      pend_q    <= 17'd0;
      pend_vld_q <= 1'b0;
      slope_q   <= nv_slope_q;
      offset_q  <= nv_offset_q;
      by_q <= nv_by_q;
      bz_q <= nv_bz_q;
      cy_q <= nv_cy_q;
      cz_q <= nv_cz_q;
      duplex_q  <= nv_duplex_q;
      interp_q  <= nv_interp_q;
      stddev_q  <= nv_stddev_q;
      nvw_q     <= 1'b0;
    end else begin
      nvw_q <= 1'b0;
      if (exec_q && id_match && writable && in_range) begin
        unique case (cmd_q)
          asci_pkg::CMD_KEY:      key_q <= par_q;
          asci_pkg::CMD_ID:       inst_id_q <= {asci_pkg::CH_ZERO +
                                    8'(par_q / 17'd10), asci_pkg::CH_ZERO +
                                    8'(par_q % 17'd10)};
          asci_pkg::CMD_STD_BAUD: baud_q <= par_q;
          asci_pkg::CMD_EXT_BAUD: begin
            baud_q <= par_q;
            if (pend_vld_q && pend_q == par_q) begin
              nvw_q <= 1'b1;
              pend_vld_q <= 1'b0;
            end else begin
              pend_q <= par_q;
              pend_vld_q <= 1'b1;
            end
          end
          asci_pkg::CMD_SLOPE:    slope_q  <= par_q;
          asci_pkg::CMD_OFFSET:   offset_q <= par_q;
          asci_pkg::CMD_B_ZERO:   by_q <= par_q;
          asci_pkg::CMD_B_FULL:   bz_q <= par_q;
          asci_pkg::CMD_C_ZERO:   cy_q <= par_q;
          asci_pkg::CMD_C_FULL:   cz_q <= par_q;
          asci_pkg::CMD_INTERP:   interp_q <= par_q[0];
          asci_pkg::CMD_STDDEV:   stddev_q <= par_q[0];
          asci_pkg::CMD_DUPLEX:   duplex_q <= par_q[1:0];
          asci_pkg::CMD_DEFAULTS: begin
            if (par_q != 17'd0) begin
              baud_q <= asci_pkg::STD_BAUD_RST;
              slope_q <= SLOPE_DEF;
              offset_q <= OFFSET_DEF;
              by_q <= asci_pkg::SCALE_RST;
              bz_q <= asci_pkg::SCALE_RST;
              cy_q <= asci_pkg::SCALE_RST;
              cz_q <= asci_pkg::SCALE_RST;
              duplex_q <= 2'(asci_pkg::DUPLEX_RST);
              interp_q <= 1'b0;
              stddev_q <= 1'b0;
              nvw_q <= par_q == asci_pkg::DEF_ALL;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // non-volatile image; the extended baud only after confirmation
  always_ff @(posedge clk) begin
    if (exec_q && id_match && writable && in_range &&
        cmd_q == asci_pkg::CMD_DEFAULTS && par_q == asci_pkg::DEF_ALL) begin
      nv_id_q <= asci_pkg::ID_RESET;
      nv_baud_q <= asci_pkg::STD_BAUD_RST;
      nv_slope_q <= SLOPE_DEF;
      nv_offset_q <= OFFSET_DEF;
      nv_by_q <= asci_pkg::SCALE_RST;
      nv_bz_q <= asci_pkg::SCALE_RST;
      nv_cy_q <= asci_pkg::SCALE_RST;
      nv_cz_q <= asci_pkg::SCALE_RST;
      nv_duplex_q <= 2'(asci_pkg::DUPLEX_RST);
      nv_interp_q <= 1'b0;
      nv_stddev_q <= 1'b0;
    end else if (exec_q && id_match && writable && in_range &&
                 cmd_q == asci_pkg::CMD_EXT_BAUD &&
                 pend_vld_q && pend_q == par_q) begin
      nv_baud_q <= par_q;
    end else if (exec_q && id_match && writable && in_range &&
                 cmd_q == asci_pkg::CMD_STD_BAUD) begin
      nv_baud_q <= par_q;
    end
  end

  // reply value for queries
  always_comb begin
    unique case (cmd_q)
      asci_pkg::CMD_STD_BAUD, asci_pkg::CMD_EXT_BAUD: reply_val = baud_q;
      asci_pkg::CMD_KEY:      reply_val = key_q;
      asci_pkg::CMD_SLOPE:    reply_val = slope_q;
      asci_pkg::CMD_OFFSET:   reply_val = offset_q;
      asci_pkg::CMD_B_ZERO:   reply_val = by_q;
      asci_pkg::CMD_B_FULL:   reply_val = bz_q;
      asci_pkg::CMD_C_ZERO:   reply_val = cy_q;
      asci_pkg::CMD_C_FULL:   reply_val = cz_q;
      asci_pkg::CMD_INTERP:   reply_val = {16'd0, interp_q};
      asci_pkg::CMD_STDDEV:   reply_val = {16'd0, stddev_q};
      asci_pkg::CMD_DUPLEX:   reply_val = {15'd0, duplex_q};
      asci_pkg::CMD_VERSION:  reply_val = VERSION_VAL;
      default:                reply_val = 17'd0;
    endcase
  end

  asci_digits u_digits (
    .value (reply_val),
    .ascii (reply_dig)
  );

  // reply sender: id, command, five digits, cr
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_q <= asci_pkg::ASCI_TX_IDLE;
      tx_cnt_q <= 4'd0;
      reply_q <= '0;
      tx_data_q <= 8'h00;
      tx_valid_q <= 1'b0;
      req_q <= 1'b0;
    end else begin
      req_q <= 1'b0;
      unique case (tx_q)
        asci_pkg::ASCI_TX_IDLE: begin
          tx_valid_q <= 1'b0;
          if (query_q && (id_match || interp_q)) begin
            if (interp_q && cmd_q == asci_pkg::CMD_DATA_REQ) begin
              req_q <= 1'b1;
            end else begin
              reply_q <= {inst_id_q, cmd_q, reply_dig[39:32],
                reply_dig[31:24], reply_dig[23:16], reply_dig[15:8],
                reply_dig[7:0], asci_pkg::CH_CR};
              tx_cnt_q <= 4'd0;
              tx_q <= asci_pkg::ASCI_TX_SEND;
            end
          end
        end
        asci_pkg::ASCI_TX_SEND: begin
          if (!tx_valid_q || tx_ready) begin
            tx_data_q <= reply_q[79:72];
            reply_q <= {reply_q[71:0], 8'h00};
            tx_valid_q <= 1'b1;
            tx_cnt_q <= tx_cnt_q + 4'd1;
            if (tx_cnt_q == 4'd9) begin
              tx_q <= asci_pkg::ASCI_TX_DONE;
            end
          end
        end
        default: begin
          if (tx_ready) begin
            tx_valid_q <= 1'b0;
            tx_q <= asci_pkg::ASCI_TX_IDLE;
          end
        end
      endcase
    end
  end

  // one-minute hold of autonomous output in half duplex
  always_ff @(posedge clk) begin
    if (srst) begin
      hold_cnt_q <= 34'd0;
      hold_q <= 1'b1;
    end else if (hold_cnt_q < 34'(HOLD_CYC)) begin
      hold_cnt_q <= hold_cnt_q + 34'd1;
      hold_q <= 1'b1;
    end else begin
      hold_q <= 1'b0;
    end
  end

  // status outputs registered; they lag their causes by one cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      sd_out_q   <= 1'b0;
      hold_out_q <= 1'b0;
    end else begin
      sd_out_q   <= stddev_q && !instantaneous_output;
      hold_out_q <= hold_q && autonomous_output &&
                    duplex_q == 2'(asci_pkg::DUPLEX_HALF);
    end
  end

  // driver enable: modes 0 and 1 only while sending, 2 always
  always_ff @(posedge clk) begin
    if (srst) begin
      // driven mode must not drop the line across a restart
      drv_q <= nv_duplex_q == 2'(asci_pkg::DUPLEX_RST);
    end else begin
      drv_q <= duplex_q == 2'(asci_pkg::DUPLEX_RST) ||
               tx_q != asci_pkg::ASCI_TX_IDLE;
    end
  end

  asci_baud_map u_baud (
    .code  (baud_q),
    .rate  (rate_w),
    .frame (frame_w)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      rate_q <= 20'd0;
      frame_q <= 2'd0;
    end else begin
      rate_q <= rate_w;
      frame_q <= frame_w;
    end
  end

  assign tx_data = tx_data_q;
  assign tx_valid = tx_valid_q;
  assign tx_driver_en = drv_q;
  assign baud_rate = rate_q;
  assign baud_frame = frame_q;
  assign key_level = key_q;
  assign interpreter_select = interp_q;
  assign stddev_enable = sd_out_q;
  assign telegram_hold = hold_out_q;
  assign regional_data_request = req_q;
  assign analog_slope_cal = slope_q;
  assign analog_offset_cal = offset_q;
  assign chan_b_zero_scale = by_q;
  assign chan_b_full_scale = bz_q;
  assign chan_c_zero_scale = cy_q;
  assign chan_c_full_scale = cz_q;
  assign duplex_select = duplex_q;
  assign nv_write = nvw_q;
endmodule : asci_interp
`default_nettype wire

// file: hdl/asci_pkg.sv
// constants, command codes and types of the ascii command interpreter
package asci_pkg;
  localparam int          CLK_HZ          = 250_000_000;
  localparam logic [7:0]  CH_CR           = 8'h0d;
  localparam logic [7:0]  CH_ZERO         = 8'h30;
  localparam int          PARAM_DIGITS    = 5;
  localparam logic [15:0] ID_RESET        = 16'h3030;
  // command codes, two ascii characters
  localparam logic [15:0] CMD_KEY         = 16'h4b59;
  localparam logic [15:0] CMD_STD_BAUD    = 16'h4252;
  localparam logic [15:0] CMD_EXT_BAUD    = 16'h4258;
  localparam logic [15:0] CMD_INTERP      = 16'h4349;
  localparam logic [15:0] CMD_DATA_REQ    = 16'h4441;
  localparam logic [15:0] CMD_STDDEV      = 16'h4445;
  localparam logic [15:0] CMD_DEFAULTS    = 16'h4446;
  localparam logic [15:0] CMD_DUPLEX      = 16'h444d;
  localparam logic [15:0] CMD_VERSION     = 16'h4456;
  localparam logic [15:0] CMD_SLOPE       = 16'h4341;
  localparam logic [15:0] CMD_OFFSET      = 16'h4342;
  localparam logic [15:0] CMD_B_ZERO      = 16'h4259;
  localparam logic [15:0] CMD_B_FULL      = 16'h425a;
  localparam logic [15:0] CMD_C_ZERO      = 16'h4359;
  localparam logic [15:0] CMD_C_FULL      = 16'h435a;
  localparam logic [15:0] CMD_ID          = 16'h4944;
  // value ranges and defaults
  localparam logic [16:0] KEY_USER        = 17'd1;
  localparam logic [16:0] STD_BAUD_MIN    = 17'd2;
  localparam logic [16:0] STD_BAUD_MAX    = 17'd49;
  localparam logic [16:0] STD_BAUD_RST    = 17'd5;
  localparam logic [16:0] EXT_BAUD_MIN    = 17'd101;
  localparam logic [16:0] EXT_BAUD_MAX    = 17'd103;
  localparam logic [16:0] SCALE_RST       = 17'd30000;
  localparam logic [16:0] SLOPE_MIN       = 17'd5900;
  localparam logic [16:0] SLOPE_MAX       = 17'd61000;
  localparam logic [16:0] SLOPE_RST       = 17'd60000;
  localparam logic [16:0] OFFSET_MIN      = 17'd800;
  localparam logic [16:0] OFFSET_MAX      = 17'd1200;
  localparam logic [16:0] OFFSET_RST      = 17'd1000;
  localparam logic [16:0] DUPLEX_HALF     = 17'd0;
  localparam logic [16:0] DUPLEX_FULL_OFF = 17'd1;
  localparam logic [16:0] DUPLEX_RST      = 17'd2;
  localparam logic [16:0] DEF_WORK       = 17'd1;
  localparam logic [16:0] DEF_ALL        = 17'd2;
  localparam logic [16:0] ID_MAX          = 17'd99;
  localparam int          HOLD_S          = 60;
  localparam int          ONE_SECOND_CYC  = CLK_HZ;
  localparam int          BAUD_RATE_W     = 20;
  typedef enum logic [1:0] {
    ASCI_RX_ID, ASCI_RX_CMD, ASCI_RX_PARAM, ASCI_RX_SKIP
  } asci_rx_t;
  typedef enum logic [1:0] {
    ASCI_TX_IDLE, ASCI_TX_SEND, ASCI_TX_DONE
  } asci_tx_t;
endpackage : asci_pkg
